// ===== can_accept_filter_control.v
// APB register block for CAN acceptance filters 24 to 29
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "can_filter_defines.vh"

module can_accept_filter_control #(
  parameter NUM_FILT = `FILT_COUNT
) (
  // Clock and reset
  input  wire                         clock,
  input  wire                         rst,
  // APB slave
  input  wire                         psel,
  input  wire                         penable,
  input  wire                         pwrite,
  input  wire [`ADDR_WIDTH-1:0]       paddr,
  input  wire [31:0]                  pwdata,
  input  wire [3:0]                   pstrb,
  output wire                         pready,
  output reg  [31:0]                  prdata_ff,
  output wire                         pslverr,
  // Matching engine side
  input  wire [NUM_FILT-1:0]          rawHit,
  output wire [NUM_FILT-1:0]          filterEnable,
  output wire [NUM_FILT*2-1:0]        maskSelect,
  output wire [NUM_FILT*5-1:0]        fifoSelect,
  output wire [NUM_FILT-1:0]          filterHit
);

  // =============================================================
  // Bus decode
  wire                  access;
  wire                  selReg0;
  wire                  selReg1;
  wire                  mapped;
  wire [NUM_FILT*8-1:0] ctrlBytes;
  wire [31:0]           reg0Value;
  wire [31:0]           reg1Value;
  reg  [31:0]           nxt_prdata;

  // Zero wait states: every access completes in its first access cycle
  assign access  = psel & penable;
  assign selReg0 = (paddr == `ADDR_FILTER_CONTROL_24_27);
  assign selReg1 = (paddr == `ADDR_FILTER_CONTROL_28_31);
  assign mapped  = selReg0 | selReg1;
  assign pready  = 1'h1;
  assign pslverr = access & ~mapped;

  // =============================================================
  // Filter slots
  genvar i;
  generate
    for (i = 0; i < NUM_FILT; i = i + 1) begin : gFilt
      wire       wrHere;
      wire [7:0] wrByte;
      if (i < `FILT_IN_REG0) begin : gReg0
        // filters 24..27 in byte lanes of first register
        assign wrHere = access & pwrite & selReg0 & pstrb[i];
        assign wrByte = pwdata[i*8 +: 8];
      end else begin : gReg1
        // filters 28..29 in low bytes of second register
        assign wrHere = access & pwrite & selReg1 & pstrb[i-`FILT_IN_REG0];
        assign wrByte = pwdata[(i-`FILT_IN_REG0)*8 +: 8];
      end

      filter_slot uSlot (
        .clock    (clock),
        .rst      (rst),
        .wrStrobe (wrHere),
        .wrByte   (wrByte),
        .ctrlByte (ctrlBytes[i*8 +: 8])
      );

      filter_route uRoute (
        .clock        (clock),
        .rst          (rst),
        .ctrlByte     (ctrlBytes[i*8 +: 8]),
        .rawHit       (rawHit[i]),
        .filterEnable (filterEnable[i]),
        .maskSelect   (maskSelect[i*2 +: 2]),
        .fifoSelect   (fifoSelect[i*5 +: 5]),
        .hit_ff       (filterHit[i])
      );
    end
  endgenerate

  // =============================================================
  // Read data
  // read image of first register
  assign reg0Value = ctrlBytes[31:0];
  // upper half reads zero, filters 30 and 31 are not here
  assign reg1Value = {16'h0000, ctrlBytes[NUM_FILT*8-1:32]};

  always @* begin
    nxt_prdata = `REG_ZERO;
    if (psel & ~penable & ~pwrite) begin
      if (selReg0) begin
        nxt_prdata = reg0Value;
      end else if (selReg1) begin
        nxt_prdata = reg1Value;
      end
    end
  end

  // Read data captured in setup so it stands in the access cycle
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_ff <= `REG_ZERO;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

endmodule // can_accept_filter_control

// ===== can_accept_filter_control_checker.sv
// Assertions on the ports of the CAN filter control block
`timescale 1ns/10ps
module can_accept_filter_control_checker #(parameter NUM_FILT = 6) (
  input logic                  clock, rst,
  input logic                  psel, penable, pwrite, pslverr,
  input logic [11:0]           paddr,
  input logic [3:0]            pstrb,
  input logic [31:0]           pwdata, prdata_ff,
  input logic [NUM_FILT-1:0]   rawHit, filterEnable, filterHit,
  input logic [NUM_FILT*2-1:0] maskSelect,
  input logic [NUM_FILT*5-1:0] fifoSelect
);
  // ==========
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire addrOk = paddr == 12'h000 || paddr == 12'h004;
  wire wr0 = acc && pwrite && paddr == 12'h000;
  a_hit_gating: assert property (filterHit == $past(rawHit & filterEnable))
    else $error("hit not gated by enable");
  a_unmapped_err: assert property (acc && !addrOk |-> pslverr)
    else $error("no error on unmapped");
  a_mapped_ok: assert property (acc && addrOk |-> !pslverr)
    else $error("error on mapped");
  a_read_idle: assert property (!psel |-> prdata_ff == 32'h0)
    else $error("read data left");
  a_lock_low: assert property ($past(filterEnable[0]) |-> $stable(fifoSelect[4:0]) && $stable(maskSelect[1:0]))
    else $error("locked filter changed");
  a_lock_top: assert property ($past(filterEnable[5]) |-> $stable(fifoSelect[29:25]))
    else $error("locked filter changed");
  a_quiet_bus: assert property (!$past(acc && pwrite) |-> $stable(filterEnable))
    else $error("enable moved");
  a_enable_write: assert property ($past(wr0 && pstrb[0]) |-> filterEnable[0] == $past(pwdata[7]))
    else $error("enable not written");
  a_fifo_write: assert property ($past(wr0 && pstrb[3] && !filterEnable[3]) |-> fifoSelect[19:15] == $past(pwdata[28:24]))
    else $error("fifo not written");
  cover property (acc && !addrOk);
  cover property (filterHit[0]);
  cover property (acc && pwrite && filterEnable[5]);
endmodule // can_accept_filter_control_checker

bind can_accept_filter_control can_accept_filter_control_checker #(.NUM_FILT(NUM_FILT)) chk_u (.*);

// ===== can_accept_filter_control_test.sv
// Self-checking bench of the CAN filter control block
`timescale 1ns/10ps
module can_accept_filter_control_test;
  logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] pwdata = 32'h0;
  logic [5:0]  rawHit = 6'h00;
  logic [31:0] m [2];
  logic [32:0] expQ [$];
  wire         pready, pslverr;
  wire [31:0]  prdata_ff;
  wire [5:0]   filterEnable, filterHit;
  wire [11:0]  maskSelect;
  wire [29:0]  fifoSelect;
  int          err_count = 0, checked = 0;
  logic [47:0] expF;
  logic [5:0]  prevHit;
  can_accept_filter_control dut_u (.*);
  initial forever #4 clock = ~clock;
  always @(posedge clock) if (!rst) rawHit <= 6'($urandom);
  task chk(input logic [47:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Fields of an enabled filter stay put, its enable is always written
  function logic [31:0] upd(logic [31:0] o, w, logic [3:0] s);
    for (int b = 0; b < 4; b++)
      if (s[b]) o[b*8+:8] = o[b*8+7] ? {w[b*8+7], o[b*8+:7]} : w[b*8+:8];
    return o;
  endfunction
  // Expected enable, mask and FIFO vectors of all six filters
  function logic [47:0] fields();
    logic [47:0] all;
    logic [5:0]  en;
    logic [11:0] ms;
    logic [29:0] fs;
    all = {m[1][15:0], m[0]};
    for (int k = 0; k < 6; k++) begin
      en[k] = all[k*8+7];
      ms[k*2+:2] = all[k*8+5+:2];
      fs[k*5+:5] = all[k*8+:5];
    end
    return {en, ms, fs};
  endfunction
  task apb(input logic wr, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    logic ok;
    ok = a == 12'h000 || a == 12'h004;
    expQ.push_back({!ok, (ok && !wr) ? m[a[2]] : 32'h0});
    if (wr && ok) m[a[2]] = upd(m[a[2]], d, s) & (a[2] ? 32'h0000FFFF : 32'hFFFFFFFF);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock) penable <= 1;
    do @(posedge clock); while (!pready);
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  // Response taken at the edge that ends the access phase
  always @(posedge clock)
    if (psel && penable && pready) chk({pslverr, prdata_ff}, expQ.pop_front());
  initial begin
    void'($urandom(57137));
    m[0] = 32'h0;
    m[1] = 32'h0;
    repeat (4) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    for (int i = 0; i < 2; i++) apb(0, 12'(i * 4), 32'h0, 4'h0);
    $display("reset test done");
    // Random traffic, unmapped places and partial strobes included
    repeat (300) begin
      apb($urandom, 12'($urandom_range(0, 3) * 4), $urandom, 4'($urandom));
      chk({filterEnable, maskSelect, fifoSelect}, fields());
    end
    for (int i = 0; i < 2; i++) apb(0, 12'(i * 4), 32'h0, 4'h0);
    chk(maskSelect[1:0], m[0][6:5]);
    chk(fifoSelect[29:25], m[1][12:8]);
    chk(filterEnable, {m[1][15], m[1][7], m[0][31], m[0][23], m[0][15], m[0][7]});
    expF = fields();
    @(posedge clock) prevHit = rawHit;
    repeat (8) begin
      @(posedge clock);
      chk(filterHit, prevHit & expF[47:42]);
      prevHit = rawHit;
    end
    $display("random test done");
    test_done;
  end
  initial begin
    #100000;
    err_count++;
    test_done;
  end
endmodule // can_accept_filter_control_test

// ===== can_filter_defines.vh
// Constants for the CAN acceptance filter control block
`ifndef CAN_FILTER_DEFINES_VH
`define CAN_FILTER_DEFINES_VH

// =============================================================
// Register map (byte addresses)
`define ADDR_FILTER_CONTROL_24_27 12'h000
`define ADDR_FILTER_CONTROL_28_31 12'h004
`define ADDR_WIDTH                12

// =============================================================
// Per-filter byte layout
`define FILT_BYTE_W   8
`define FILT_EN_BIT   7
`define FILT_MSEL_HI  6
`define FILT_MSEL_LO  5
`define FILT_FSEL_HI  4
`define FILT_FSEL_LO  0
`define MSEL_W        2
`define FSEL_W        5

// =============================================================
// Filter numbering and reset values
`define FILT_BASE     24
`define FILT_COUNT    6
`define FILT_IN_REG0  4
`define FILT_RESET    8'h00
`define REG_ZERO      32'h00000000

`endif

// ===== filter_route.v
// Decodes one filter byte into match gating, mask select and FIFO select
`timescale 1ns/10ps
`include "can_filter_defines.vh"

module filter_route (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Control byte and raw match
  input  wire [7:0] ctrlByte,
  input  wire       rawHit,
  // Decoded outputs
  output wire       filterEnable,
  output wire [1:0] maskSelect,
  output wire [4:0] fifoSelect,
  output reg        hit_ff
);

  assign filterEnable = ctrlByte[`FILT_EN_BIT];
  assign maskSelect   = ctrlByte[`FILT_MSEL_HI:`FILT_MSEL_LO];
  assign fifoSelect   = ctrlByte[`FILT_FSEL_HI:`FILT_FSEL_LO];

  // =============================================================
  // Gated match, registered
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      hit_ff <= 1'h0;
    end else begin
      hit_ff <= rawHit & filterEnable;
    end
  end

endmodule // filter_route

// ===== filter_slot.v
// One acceptance filter control byte with write lock while enabled
`timescale 1ns/10ps
`include "can_filter_defines.vh"

module filter_slot (
  // Clock and reset
  input  wire       clock,
  input  wire       rst,
  // Write request
  input  wire       wrStrobe,
  input  wire [7:0] wrByte,
  // State
  output wire [7:0] ctrlByte
);

  reg  [7:0] slot_ff;
  reg  [7:0] nxt_slot;
  wire       enabled;

  assign enabled  = slot_ff[`FILT_EN_BIT];
  assign ctrlByte = slot_ff;

  // =============================================================
  // Next value
  always @* begin
    nxt_slot = slot_ff;
    if (wrStrobe) begin
      if (!enabled) begin
        nxt_slot = wrByte;
      end else begin
        // enable bit always writable, so software can disable
        nxt_slot[`FILT_EN_BIT] = wrByte[`FILT_EN_BIT];
      end
    end
  end

  // =============================================================
  // Storage
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      slot_ff <= `FILT_RESET;
    end else begin
      slot_ff <= nxt_slot;
    end
  end

endmodule // filter_slot
